// >>> dv/pin_partner.sv
// Purpose: far-side view of one pin with no pull resistor
// Assumes: oe_n low means the block drives the pin
// Notes: a released pin shows the inverse of the last driven level, so a stale value never passes
`timescale 1ns/100ps
module pin_partner (
    input wire logic sys_clk,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    output logic pin_level
);
    logic last_reg = 1'h0; // last level the block drove
    // remember what was driven while the pin is held
    always_ff @(posedge sys_clk) begin
        if (!pin_oe_n) last_reg <= pin_out;
    end
    assign pin_level = pin_oe_n ? ~last_reg : pin_out;
endmodule

// >>> dv/pins_checker.sv
// Purpose: concurrent checks on pin function selection and pin drive
// Assumes: one clock domain, pins registered one cycle after the flags
// Notes: keeps its own copy of the pull-up option, taken at the first edge after reset
`timescale 1ns/100ps
module pins_checker
    import pin_ctrl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic interrupt_pin_select,
    input wire logic single_wire_mode,
    input wire logic power_off_enable,
    input wire logic arm_power_off_cmd,
    input wire logic disarm_power_off_cmd,
    input wire logic power_off_pin_polarity,
    input wire logic pin_pullup_enable,
    input wire logic interrupt_polarity,
    input wire logic [1:0] power_mode,
    input wire logic hibernate_low_voltage,
    input wire logic comm_tx_out,
    input wire logic comm_tx_oe_n,
    input wire logic power_off_armed_flag,
    input wire logic power_off_request_flag,
    input wire logic interrupt_active,
    input wire logic power_off_pin_out,
    input wire logic power_off_pin_oe_n,
    input wire logic single_wire_pin_out,
    input wire logic single_wire_pin_oe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic [1:0] cnt_reg; // edges since reset release, saturating
    logic pu_reg; // pull-up option as held by the block
    // edge count, so pin checks wait until the capture edge has passed
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) cnt_reg <= 2'h0;
        else if (cnt_reg != 2'h3) cnt_reg <= cnt_reg + 2'h1;
    end
    // later changes of the option are ignored until the next reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) pu_reg <= 1'h0;
        else if (cnt_reg == 2'h0) pu_reg <= pin_pullup_enable;
    end
    // expected {oe_n, out}; without pull-up the pin is released when s equals pol
    function automatic logic [1:0] drv(input logic pu, input logic pol, input logic s);
        drv = pu ? {1'h0, s ~^ pol} : {s ~^ pol, 1'h0};
    endfunction
    sequence s_arm_req;
        arm_power_off_cmd;
    endsequence
    a_pins_start_z: assert property (cnt_reg < 2'h2 |-> power_off_pin_oe_n && single_wire_pin_oe_n)
        else $error("pin driven too early after reset");
    a_arm_sets: assert property (s_arm_req |=> power_off_armed_flag)
        else $error("arm did not set the armed flag");
    a_disarm_clears: assert property (disarm_power_off_cmd && !arm_power_off_cmd && !power_off_enable
        |=> !power_off_armed_flag)
        else $error("disarm left the armed flag set");
    a_request_cond: assert property (cnt_reg != 2'h0 |-> power_off_request_flag ==
        $past(power_off_armed_flag && power_mode == MODE_HIBERNATE && hibernate_low_voltage))
        else $error("request flag does not follow armed low-voltage hibernate");
    a_po_pin_drive: assert property (cnt_reg >= 2'h2 |->
        {power_off_pin_oe_n, power_off_pin_out} == $past(interrupt_pin_select
        ? drv(pu_reg, power_off_pin_polarity, power_off_request_flag)
        : drv(pu_reg, interrupt_polarity, interrupt_active)))
        else $error("power-off pin drive wrong");
    a_wire_int_drive: assert property (cnt_reg >= 2'h2 &&
        $past(interrupt_pin_select && !single_wire_mode)
        |-> {single_wire_pin_oe_n, single_wire_pin_out} == $past(drv(1'h0, interrupt_polarity, interrupt_active)))
        else $error("single-wire interrupt drive wrong");
    a_wire_comm_pass: assert property (cnt_reg >= 2'h2 && $past(single_wire_mode)
        |-> {single_wire_pin_oe_n, single_wire_pin_out} == $past({comm_tx_oe_n, comm_tx_out}))
        else $error("link drive not passed to the wire pin");
    a_wire_idle_z: assert property (cnt_reg >= 2'h2 && $past(!interrupt_pin_select && !single_wire_mode)
        |-> single_wire_pin_oe_n)
        else $error("unused wire pin is driven");
endmodule

// >>> dv/power_off_and_interrupt_pins_tb.sv
// Purpose: directed tests of pin selection, power-off arming and interrupt drive
// Assumes: inputs change at the falling edge; pins settle two edges after a flag input
// Notes: expected drive is worked out here from the pin tables
`timescale 1ns/100ps
module power_off_and_interrupt_pins_tb
    import pin_ctrl_pkg::*;
;
    logic sys_clk = 1'h0; // 100 ns clock
    logic nrst = 1'h0; // reset, active low
    logic interrupt_pin_select = 1'h0, single_wire_mode = 1'h0, power_off_enable = 1'h0; // selection
    logic arm_power_off_cmd = 1'h0, disarm_power_off_cmd = 1'h0, hibernate_low_voltage = 1'h0; // commands
    logic power_off_pin_polarity = 1'h0, pin_pullup_enable = 1'h0, interrupt_polarity = 1'h0; // pin options
    logic [1:0] power_mode = MODE_NORMAL; // power mode code
    logic [6:0] flt = 7'h00; // faults: level, high, low, hot chg, hot dsg, short, tab
    logic [3:0] en = 4'h0; // enables of the last four sources
    logic charge_level_flag, high_voltage_flag, low_voltage_flag, hot_charge_flag;
    logic hot_discharge_flag, internal_short_flag, tab_loss_flag;
    logic hot_charge_time_nonzero, hot_discharge_time_nonzero, internal_short_enable, tab_loss_enable;
    logic comm_tx_out = 1'h0, comm_tx_oe_n = 1'h1, comm_host_int_req = 1'h0; // link side
    logic single_wire_pin_in, comm_rx, comm_host_int_pending, interrupt_active; // wire level and status
    logic power_off_armed_flag, power_off_request_flag, power_off_pin_out, power_off_pin_oe_n;
    logic single_wire_pin_out, single_wire_pin_oe_n;
    int err_total = 0, cmp_count = 0, cyc = 0;
    wire [1:0] po = {power_off_pin_oe_n, power_off_pin_out}; // power-off pin {oe_n, out}
    wire [1:0] sw = {single_wire_pin_oe_n, single_wire_pin_out}; // wire pin {oe_n, out}
    assign {tab_loss_flag, internal_short_flag, hot_discharge_flag, hot_charge_flag} = flt[6:3];
    assign {low_voltage_flag, high_voltage_flag, charge_level_flag} = flt[2:0];
    assign {tab_loss_enable, internal_short_enable, hot_discharge_time_nonzero, hot_charge_time_nonzero} = en;
    power_off_and_interrupt_pins dut_u (.*);
    pin_partner wire_u (.sys_clk(sys_clk), .pin_out(single_wire_pin_out), .pin_oe_n(single_wire_pin_oe_n),
        .pin_level(single_wire_pin_in));
    // clock of 100 ns period
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // hang guard: the tests need well under this many cycles
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            report_and_stop();
        end
    end
    function automatic logic [1:0] drv(input logic pu, input logic pol, input logic s);
        drv = pu ? {1'h0, s ~^ pol} : {s ~^ pol, 1'h0};
    endfunction
    task automatic step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic pulse_arm(input logic arm);
        arm_power_off_cmd = arm;
        disarm_power_off_cmd = ~arm;
        step(1);
        arm_power_off_cmd = 1'h0;
        disarm_power_off_cmd = 1'h0;
        step(3);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        step(16);
        chk(po, 2'h2);
        nrst = 1'h1;
        step(3);
        chk({power_off_armed_flag, power_off_request_flag}, 2'h0);
        chk(sw, 2'h2);
        // each source in both polarities; the four sources with an enable also with it off
        for (int p = 0; p < 2; p++) for (int i = 0; i < 7; i++) for (int e = 0; e < 2; e++) begin
            interrupt_polarity = p[0];
            en = e ? 4'hF : ~(4'h8 >> (6 - i)); // only this source's own enable is off; for the first three sources no enable is off
            flt = 7'h01 << i;
            step(3);
            chk(po, drv(1'h0, p[0], (i < 3) || e[0]));
            chk({1'h0, interrupt_active}, {1'h0, (i < 3) || e[0]});
            flt = 7'h00;
            step(3);
            chk(po, drv(1'h0, p[0], 1'h0));
        end
        $display("interrupt sources done");
        interrupt_pin_select = 1'h1;
        power_mode = MODE_HIBERNATE;
        hibernate_low_voltage = 1'h1;
        for (int p = 0; p < 2; p++) begin
            power_off_pin_polarity = p[0];
            pulse_arm(1'h1);
            chk({power_off_armed_flag, power_off_request_flag}, 2'h3);
            chk(po, drv(1'h0, p[0], 1'h1));
            power_mode = MODE_SLEEP;
            step(3);
            chk(po, drv(1'h0, p[0], 1'h0));
            power_mode = MODE_HIBERNATE;
            hibernate_low_voltage = 1'h0;
            step(3);
            chk(po, drv(1'h0, p[0], 1'h0));
            hibernate_low_voltage = 1'h1;
            pulse_arm(1'h0);
            chk({1'h0, power_off_armed_flag}, 2'h0);
            chk(po, drv(1'h0, p[0], 1'h0));
        end
        interrupt_pin_select = 1'h0;
        power_off_enable = 1'h1;
        step(4);
        chk({power_off_armed_flag, power_off_request_flag}, 2'h3);
        chk(po, drv(1'h0, 1'h1, 1'h0));
        power_off_enable = 1'h0;
        step(3);
        chk({1'h0, power_off_armed_flag}, 2'h0);
        $display("power-off arming done");
        interrupt_pin_select = 1'h1;
        for (int p = 0; p < 2; p++) begin
            interrupt_polarity = p[0];
            flt = 7'h04;
            step(3);
            chk(sw, drv(1'h0, p[0], 1'h1));
            flt = 7'h00;
            step(3);
            chk(sw, drv(1'h0, p[0], 1'h0));
        end
        single_wire_mode = 1'h1;
        comm_tx_oe_n = 1'h0;
        comm_tx_out = 1'h1;
        flt = 7'h02;
        step(4);
        chk(sw, 2'h1);
        chk({comm_rx, comm_host_int_pending}, 2'h3);
        flt = 7'h00;
        comm_host_int_req = 1'h1;
        step(1);
        comm_host_int_req = 1'h0;
        comm_tx_out = 1'h0;
        step(3);
        chk({comm_rx, comm_host_int_pending}, 2'h0);
        single_wire_mode = 1'h0;
        comm_tx_oe_n = 1'h1;
        $display("wire pin done");
        interrupt_pin_select = 1'h0;
        interrupt_polarity = 1'h0;
        pin_pullup_enable = 1'h1;
        step(3);
        chk(po, drv(1'h0, 1'h0, 1'h0));
        nrst = 1'h0;
        step(2);
        chk(po, 2'h2);
        nrst = 1'h1;
        step(3);
        chk(po, drv(1'h1, 1'h0, 1'h0));
        flt = 7'h01;
        step(3);
        chk(po, drv(1'h1, 1'h0, 1'h1));
        interrupt_pin_select = 1'h1;
        power_off_pin_polarity = 1'h0;
        flt = 7'h00;
        step(3);
        chk(sw, drv(1'h0, 1'h0, 1'h0));
        chk(po, drv(1'h1, 1'h0, 1'h0));
        $display("pull-up done");
        report_and_stop();
    end
endmodule
bind power_off_and_interrupt_pins pins_checker chk_u (.*);

// >>> rtl/pin_ctrl_pkg.sv
// Purpose: shared constants and types for the power-off / interrupt pin logic
// Assumes: one 10 MHz clock, no register bus
// Notes: pin drive is expressed as output value plus active-low enable
package pin_ctrl_pkg;
    // reset values
    localparam logic ARMED_RST = 1'h0;
    localparam logic PULLUP_RST = 1'h0;
    localparam logic INT_RST = 1'h0;
    localparam logic REQ_RST = 1'h0;
    localparam logic HOST_INT_RST = 1'h0;
    localparam logic TAKEN_RST = 1'h0;
    localparam logic ENABLE_D_RST = 1'h0;
    // idle level of the wire pin synchroniser after reset
    localparam logic RX_IDLE_RST = 1'h1;
    // pin drive after reset: released (high impedance)
    localparam logic PIN_OUT_RST = 1'b0;
    localparam logic PIN_OE_N_RST = 1'b1;
    // count of fault sources
    localparam int FAULT_COUNT = 7;
    // power mode codes
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_FULLSLEEP = 2'b10,
        MODE_HIBERNATE = 2'b11
    } power_mode_t;
    // pin function selection
    typedef enum logic [1:0] {
        FUNC_INTERRUPT = 2'b00,
        FUNC_POWER_OFF = 2'b01,
        FUNC_COMM = 2'b10,
        FUNC_UNUSED = 2'b11
    } pin_func_t;
endpackage

// >>> rtl/power_off_and_interrupt_pins.sv
// Purpose: selects and drives the power-off pin and the single-wire pin
// Assumes: config bits and fault flags come from logic on sys_clk; host link input is a pin
// Notes: oe_n low means the pin is driven; oe_n high means high impedance
//        interrupt pins follow the fault flags two clock cycles late; no filtering is done here
//        pull-up choice is latched once after reset, so a live change is ignored until the next reset
//
// What this block does
// - select low: power-off pin interrupts, wire pin comm/unused
// - select high: power-off pin shuts down, wire pin interrupts/comm
// - arm command or enable bit sets armed flag
// - disarm command or cleared enable disables feature
// - power-off output defaults to normal state
// - power-off state only in low-voltage hibernate
// - pull-up and polarity pick power-off drive
// - power-off pin high impedance at power-on reset
// - pull-up setting captured only at reset release
// - pin select never alters flag behaviour
// - interrupt function keeps flags, no power-off signalling
// - wire pin offers host interrupt in comm mode
// - faults signal host on the selected pin
// - pull-up and polarity pick power-off pin interrupt drive
// - pull-up applies to power-off pin only
// - fault source enables on four of the seven flags
`timescale 1ns/100ps
module power_off_and_interrupt_pins
    import pin_ctrl_pkg::*;
(
    input wire logic sys_clk,                // 10 MHz system clock
    input wire logic nrst,                   // asynchronous reset, active low
    input wire logic interrupt_pin_select,   // 0: interrupt on power-off pin
    input wire logic single_wire_mode,       // 1: single-wire link is the host interface
    input wire logic power_off_enable,       // pack setting enabling power-off
    input wire logic arm_power_off_cmd,      // one-cycle arm subcommand pulse
    input wire logic disarm_power_off_cmd,   // one-cycle disarm subcommand pulse
    input wire logic power_off_pin_polarity, // power-off polarity
    input wire logic pin_pullup_enable,      // pull-up option for power-off pin
    input wire logic interrupt_polarity,     // interrupt polarity
    input wire logic [1:0] power_mode,       // current power mode
    input wire logic hibernate_low_voltage,  // hibernate entered due to low cell voltage
    input wire logic charge_level_flag,
    input wire logic high_voltage_flag,
    input wire logic low_voltage_flag,
    input wire logic hot_charge_flag,
    input wire logic hot_discharge_flag,
    input wire logic internal_short_flag,
    input wire logic tab_loss_flag,
    input wire logic hot_charge_time_nonzero,
    input wire logic hot_discharge_time_nonzero,
    input wire logic internal_short_enable,
    input wire logic tab_loss_enable,
    input wire logic comm_tx_out,            // link transmitter drive value
    input wire logic comm_tx_oe_n,           // link transmitter enable, active low
    input wire logic comm_host_int_req,      // link acknowledge pulse from link logic; clears the pending host interrupt
    input wire logic single_wire_pin_in,     // pad level of the single-wire pin
    output logic comm_rx,                    // synchronised single-wire level
    output logic comm_host_int_pending,      // host interrupt to be offered on the link
    output logic power_off_armed_flag,       // status word: feature armed
    output logic power_off_request_flag,     // status word: power-off condition present
    output logic interrupt_active,           // interrupt condition, for status
    output logic power_off_pin_out,
    output logic power_off_pin_oe_n,
    output logic single_wire_pin_out,
    output logic single_wire_pin_oe_n
);

    logic armed_reg;          // power-off feature armed
    logic pullup_reg;         // pull-up setting latched after reset
    logic pullup_taken_reg;   // pull-up already captured since reset
    logic int_reg;            // registered interrupt condition
    logic req_reg;            // registered power-off request
    logic rx_meta_reg;        // first synchroniser stage
    logic rx_sync_reg;        // second synchroniser stage
    logic host_int_reg;       // pending link host interrupt
    logic po_out_reg;
    logic po_oe_n_reg;
    logic sw_out_reg;
    logic sw_oe_n_reg;
    logic enable_d_reg;       // previous enable bit, for edge detection

    // combinational next values and decodes
    logic [FAULT_COUNT-1:0] fault_flags; // raw fault levels, one bit per source
    logic [FAULT_COUNT-1:0] fault_enables; // per-source enable
    logic [FAULT_COUNT-1:0] fault_live; // faults that may raise the interrupt
    logic int_next;
    logic req_next;
    pin_func_t po_func;
    pin_func_t sw_func;
    logic po_out_next;
    logic po_oe_n_next;
    logic sw_out_next;
    logic sw_oe_n_next;

    // fault sources and their enables
    assign fault_flags = {tab_loss_flag, internal_short_flag, hot_discharge_flag, hot_charge_flag,
                          low_voltage_flag, high_voltage_flag, charge_level_flag};
    assign fault_enables = {tab_loss_enable, internal_short_enable, hot_discharge_time_nonzero,
                            hot_charge_time_nonzero, 1'h1, 1'h1, 1'h1};

    // one gate per source
    genvar gi;
    generate
        for (gi = 0; gi < FAULT_COUNT; gi = gi + 1) begin : g_fault
            assign fault_live[gi] = fault_flags[gi] & fault_enables[gi];
        end
    endgenerate

    // level interrupt: follows the enabled faults, clears when all are gone
    assign int_next = |fault_live;

    // power-off condition, independent of pin selection
    assign req_next = armed_reg && (power_mode == MODE_HIBERNATE) && hibernate_low_voltage;

    // pin function decode
    always_comb begin
        if (!interrupt_pin_select) begin
            po_func = FUNC_INTERRUPT;
            sw_func = single_wire_mode ? FUNC_COMM : FUNC_UNUSED;
        end else begin
            po_func = FUNC_POWER_OFF;
            sw_func = single_wire_mode ? FUNC_COMM : FUNC_INTERRUPT;
        end
    end

    // power-off pin drive tables; pull-up uses the latched copy
    // out and oe_n are both set on every path, so no latch is inferred
    always_comb begin
        po_out_next = PIN_OUT_RST;
        po_oe_n_next = PIN_OE_N_RST;
        case (po_func)
            FUNC_POWER_OFF: begin
                // request false is the normal state; interrupt function never reaches here
                case ({pullup_reg, power_off_pin_polarity})
                    2'h0: begin
                        // normal released, power-off pulls low
                        po_out_next = 1'h0;
                        po_oe_n_next = ~req_reg;
                    end
                    2'h1: begin
                        // normal low, power-off released for an external pull-up
                        po_out_next = 1'h0;
                        po_oe_n_next = req_reg;
                    end
                    2'h2: begin
                        // push-pull, normal high
                        po_out_next = ~req_reg;
                        po_oe_n_next = 1'h0;
                    end
                    default: begin
                        // push-pull, normal low
                        po_out_next = req_reg;
                        po_oe_n_next = 1'h0;
                    end
                endcase
            end
            FUNC_INTERRUPT: begin
                // power-off signalling is suppressed here, flags still run
                case ({pullup_reg, interrupt_polarity})
                    2'h0: begin
                        po_out_next = 1'h0;
                        po_oe_n_next = ~int_reg;
                    end
                    2'h1: begin
                        po_out_next = 1'h0;
                        po_oe_n_next = int_reg;
                    end
                    2'h2: begin
                        po_out_next = ~int_reg;
                        po_oe_n_next = 1'h0;
                    end
                    default: begin
                        po_out_next = int_reg;
                        po_oe_n_next = 1'h0;
                    end
                endcase
            end
            default: begin
                // no other function reaches this pin; keep it released
                po_out_next = PIN_OUT_RST;
                po_oe_n_next = PIN_OE_N_RST;
            end
        endcase
    end

    // single-wire pin drive; no pull-up option on this pin
    always_comb begin
        sw_out_next = PIN_OUT_RST;
        sw_oe_n_next = PIN_OE_N_RST;
        case (sw_func)
            FUNC_COMM: begin
                sw_out_next = comm_tx_out;
                sw_oe_n_next = comm_tx_oe_n;
            end
            FUNC_INTERRUPT: begin
                // open-drain style only, always drives low; polarity chooses when the pin is driven
                // no pull-up option here: the latched pull-up bit is never read for this pin
                sw_out_next = 1'h0;
                sw_oe_n_next = interrupt_polarity ? int_reg : ~int_reg;
            end
            default: begin
                sw_out_next = PIN_OUT_RST; // unused: released
                sw_oe_n_next = PIN_OE_N_RST;
            end
        endcase
    end

    // armed flag: arm wins over disarm in the same cycle so no request is lost
    // a held enable bit arms only on its rising edge, so a later disarm command still acts
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            armed_reg <= ARMED_RST;
            enable_d_reg <= ENABLE_D_RST;
        end else begin
            enable_d_reg <= power_off_enable;
            if (arm_power_off_cmd || (power_off_enable && !enable_d_reg)) begin
                armed_reg <= 1'h1;
            end else if (disarm_power_off_cmd || (!power_off_enable && enable_d_reg)) begin
                armed_reg <= 1'h0;
            end
        end
    end

    // pull-up captured once after reset release; later changes wait for next reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pullup_reg <= PULLUP_RST;
            pullup_taken_reg <= TAKEN_RST;
        end else if (!pullup_taken_reg) begin
            pullup_reg <= pin_pullup_enable;
            pullup_taken_reg <= 1'h1;
        end
    end

    // registered conditions
    // the power-off pin reads both, so a fault and a power-off request line up in time
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            int_reg <= INT_RST;
            req_reg <= REQ_RST;
        end else begin
            int_reg <= int_next;
            req_reg <= req_next;
        end
    end

    // link host-interrupt: set wins over the link's acknowledge
    // a fault that stands through the acknowledge keeps the request pending
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            host_int_reg <= HOST_INT_RST;
        end else if (sw_func == FUNC_COMM && int_next) begin
            host_int_reg <= 1'h1;
        end else if (comm_host_int_req || sw_func != FUNC_COMM) begin
            host_int_reg <= 1'h0;
        end
    end

    // pin input synchroniser
    // resets to the idle-high level so the link sees no false edge after reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_meta_reg <= RX_IDLE_RST;
            rx_sync_reg <= RX_IDLE_RST;
        end else begin
            rx_meta_reg <= single_wire_pin_in;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    // pin drive registers; released during reset whatever the polarity
    // outputs are taken straight from these flops, so the pads never see decode glitches
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            po_out_reg <= PIN_OUT_RST;
            po_oe_n_reg <= PIN_OE_N_RST;
            sw_out_reg <= PIN_OUT_RST;
            sw_oe_n_reg <= PIN_OE_N_RST;
        end else if (!pullup_taken_reg) begin
            // first cycle: pull-up not yet known, keep pins released
            po_out_reg <= PIN_OUT_RST;
            po_oe_n_reg <= PIN_OE_N_RST;
            sw_out_reg <= PIN_OUT_RST;
            sw_oe_n_reg <= PIN_OE_N_RST;
        end else begin
            po_out_reg <= po_out_next;
            po_oe_n_reg <= po_oe_n_next;
            sw_out_reg <= sw_out_next;
            sw_oe_n_reg <= sw_oe_n_next;
        end
    end

    // every output below is a plain copy of a register
    assign comm_rx = rx_sync_reg;
    assign comm_host_int_pending = host_int_reg;
    assign power_off_armed_flag = armed_reg;
    assign power_off_request_flag = req_reg;
    assign interrupt_active = int_reg;
    assign power_off_pin_out = po_out_reg;
    assign power_off_pin_oe_n = po_oe_n_reg;
    assign single_wire_pin_out = sw_out_reg;
    assign single_wire_pin_oe_n = sw_oe_n_reg;

endmodule
